/* File: design/t16c_defines.vh */
`ifndef T16C_DEFINES_VH
`define T16C_DEFINES_VH

`define T16C_ADDR_FLAGS    8'h0B
`define T16C_ADDR_MASK     8'h0C
`define T16C_ADDR_CAP_LO   8'h24
`define T16C_ADDR_CAP_HI   8'h25

`define T16C_BIT_CAPTURE   5
`define T16C_BIT_MATCH_B   2
`define T16C_BIT_MATCH_A   1
`define T16C_BIT_WRAP      0
`define T16C_IRQ_BITS      8'h27

`define T16C_RESET_FLAGS   8'h00
`define T16C_RESET_MASK    8'h00
`define T16C_RESET_CAPTURE 16'h0000

`define T16C_CS_STOP       3'h0
`define T16C_CS_DIRECT     3'h1
`define T16C_CS_DIV8       3'h2
`define T16C_CS_DIV64      3'h3
`define T16C_CS_DIV256     3'h4
`define T16C_CS_DIV1024    3'h5
`define T16C_CS_PIN_FALL   3'h6
`define T16C_CS_PIN_RISE   3'h7

`define T16C_PRESC_WIDTH   10
`define T16C_TAP8          10'h007
`define T16C_TAP64         10'h03F
`define T16C_TAP256        10'h0FF
`define T16C_TAP1024       10'h3FF

`define T16C_WGM_PFC_CAP   4'h8
`define T16C_WGM_PC_CAP    4'hA
`define T16C_WGM_CTC_CAP   4'hC
`define T16C_WGM_FAST_CAP  4'hE

`endif

/* File: design/t16c_top.v */
// Chosen here: strobed register access.
`timescale 1ns/1ns
`include "t16c_defines.vh"

module t16c_top (
  clock,
  rst_b,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  counter_value,
  compare_a_value,
  compare_b_value,
  counter_wrap,
  waveform_mode_bits,
  clock_select_bits,
  clock_select_t0_bits,
  prescaler_reset,
  capture_pin,
  comparator_out,
  comparator_capture_sel,
  capture_edge_select,
  ext_count_pin,
  ext_count_pin_t0,
  global_irq_en,
  irq_ack,
  irq_req,
  count_tick,
  count_tick_t0,
  capture_top,
  temp_byte
);
  input  wire        clock;
  input  wire        rst_b;
  input  wire [7:0]  reg_addr;
  input  wire [7:0]  reg_wdata;
  input  wire        reg_wr;
  input  wire        reg_rd;
  output reg  [7:0]  reg_rdata;
  input  wire [15:0] counter_value;
  input  wire [15:0] compare_a_value;
  input  wire [15:0] compare_b_value;
  input  wire        counter_wrap;
  input  wire [3:0]  waveform_mode_bits;
  input  wire [2:0]  clock_select_bits;
  input  wire [2:0]  clock_select_t0_bits;
  input  wire        prescaler_reset;
  input  wire        capture_pin;
  input  wire        comparator_out;
  input  wire        comparator_capture_sel;
  input  wire        capture_edge_select;
  input  wire        ext_count_pin;
  input  wire        ext_count_pin_t0;
  input  wire        global_irq_en;
  input  wire [3:0]  irq_ack;
  output wire [3:0]  irq_req;
  output wire        count_tick;
  output wire        count_tick_t0;
  output wire [15:0] capture_top;
  output wire [7:0]  temp_byte;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // True on the last count of a power-of-two tap
  function tap_hit;
    input [9:0]  pv;
    input [9:0]  mask;
    begin
      tap_hit = ((pv & mask) == mask);
    end
  endfunction

  // Tick for one timer from its own select; pin edges skip the taps
  function tick_for;
    input [2:0]  sel;
    input [9:0]  pv;
    input        rise;
    input        fall;
    begin
      case (sel)
        `T16C_CS_STOP:     tick_for = 1'b0;
        `T16C_CS_DIRECT:   tick_for = 1'b1;
        `T16C_CS_DIV8:     tick_for = tap_hit(pv, `T16C_TAP8);
        `T16C_CS_DIV64:    tick_for = tap_hit(pv, `T16C_TAP64);
        `T16C_CS_DIV256:   tick_for = tap_hit(pv, `T16C_TAP256);
        `T16C_CS_DIV1024:  tick_for = tap_hit(pv, `T16C_TAP1024);
        `T16C_CS_PIN_FALL: tick_for = fall;
        `T16C_CS_PIN_RISE: tick_for = rise;
        default:           tick_for = 1'b0;
      endcase
    end
  endfunction

  // Packs the four event bits into register positions
  function [7:0] irq_pack;
    input [3:0] ev;
    begin
      irq_pack = 8'h00;
      irq_pack[`T16C_BIT_CAPTURE] = ev[3];
      irq_pack[`T16C_BIT_MATCH_B] = ev[2];
      irq_pack[`T16C_BIT_MATCH_A] = ev[1];
      irq_pack[`T16C_BIT_WRAP]    = ev[0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  reg  [7:0]  irq_flags;
  reg  [7:0]  irq_mask;
  reg  [15:0] capture_value;
  reg  [7:0]  temp_high;
  reg  [9:0]  presc;

  reg         ext_latch;
  reg         ext_sync;
  reg         ext_prev;
  reg         ext_old;
  reg         ext_latch_t0;
  reg         ext_sync_t0;
  reg         ext_prev_t0;
  reg         ext_old_t0;

  reg         cap_meta;
  reg         cap_sync;
  reg         cap_prev;

  reg  [7:0]  next_flags;
  reg  [7:0]  flag_set;
  reg  [7:0]  flag_clear;

  wire        wr_flags;
  wire        wr_mask;
  wire        wr_cap_lo;
  wire        wr_cap_hi;
  wire        rd_cap_lo;
  wire        cap_is_top;
  wire        cap_src;
  wire        cap_edge;
  wire        cap_event;
  wire        ext_rise;
  wire        ext_fall;
  wire        ext_rise_t0;
  wire        ext_fall_t0;

  assign wr_flags  = reg_wr & (reg_addr == `T16C_ADDR_FLAGS);
  assign wr_mask   = reg_wr & (reg_addr == `T16C_ADDR_MASK);
  assign wr_cap_lo = reg_wr & (reg_addr == `T16C_ADDR_CAP_LO);
  assign wr_cap_hi = reg_wr & (reg_addr == `T16C_ADDR_CAP_HI);
  assign rd_cap_lo = reg_rd & (reg_addr == `T16C_ADDR_CAP_LO);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------

  // Modes 8, 10, 12 and 14 take the period from the capture register;
  // the reserved mode 13 is left out on purpose
  assign cap_is_top = (waveform_mode_bits == `T16C_WGM_PFC_CAP) |
                      (waveform_mode_bits == `T16C_WGM_PC_CAP)  |
                      (waveform_mode_bits == `T16C_WGM_CTC_CAP) |
                      (waveform_mode_bits == `T16C_WGM_FAST_CAP);

  assign capture_top = capture_value;
  assign temp_byte   = temp_high;

  // ----------------------------------------------------------------
  // Shared prescaler
  // ----------------------------------------------------------------

  // Free running; select changes never touch it, so the first
  // prescaled count lands 1 to N clocks after selection
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      presc <= 10'h000;
    end else if (prescaler_reset) begin
      presc <= 10'h000;
    end else begin
      presc <= presc + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // Count pin sampling, timer16
  // ----------------------------------------------------------------

  // A high-phase latch ahead of a rising-edge flop passes on what the
  // pin showed at the falling edge; a falling-edge flop does the same
  // job without level-sensitive storage in the netlist
  always @(negedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ext_latch <= 1'b0;
    end else begin
      ext_latch <= ext_count_pin;
    end
  end

  // Sync stage, then two history stages; the edge is read between the
  // history stages so a pin edge reaches the counter 2.5 to 3.5 clocks
  // later, whatever its phase against the clock
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
      ext_old  <= 1'b0;
    end else begin
      ext_sync <= ext_latch;
      ext_prev <= ext_sync;
      ext_old  <= ext_prev;
    end
  end

  // All stages reset low like an idle pin, so no false edge follows
  // reset; a pin already high at reset gives one rising tick
  assign ext_rise = ext_prev & ~ext_old;
  assign ext_fall = ~ext_prev & ext_old;

  // ----------------------------------------------------------------
  // Count pin sampling, other timer
  // ----------------------------------------------------------------

  // Same chain as above for the other timer's pin
  always @(negedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ext_latch_t0 <= 1'b0;
    end else begin
      ext_latch_t0 <= ext_count_pin_t0;
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ext_sync_t0 <= 1'b0;
      ext_prev_t0 <= 1'b0;
      ext_old_t0  <= 1'b0;
    end else begin
      ext_sync_t0 <= ext_latch_t0;
      ext_prev_t0 <= ext_sync_t0;
      ext_old_t0  <= ext_prev_t0;
    end
  end

  assign ext_rise_t0 = ext_prev_t0 & ~ext_old_t0;
  assign ext_fall_t0 = ~ext_prev_t0 & ext_old_t0;

  // ----------------------------------------------------------------
  // Timer clock enables
  // ----------------------------------------------------------------

  // Pin edges go straight to the tick; no divider sits in their path.
  // Counter moves on the edge after the tick.
  assign count_tick = tick_for(clock_select_bits, presc,
                               ext_rise, ext_fall);
  assign count_tick_t0 = tick_for(clock_select_t0_bits, presc,
                                  ext_rise_t0, ext_fall_t0);

  // ----------------------------------------------------------------
  // Capture input
  // ----------------------------------------------------------------

  assign cap_src = comparator_capture_sel ? comparator_out : capture_pin;

  // Two sync flops, then one history flop for the edge; switching the
  // source can itself look like an edge, so clear the flag afterwards
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cap_meta <= 1'b0;
      cap_sync <= 1'b0;
      cap_prev <= 1'b0;
    end else begin
      cap_meta <= cap_src;
      cap_sync <= cap_meta;
      cap_prev <= cap_sync;
    end
  end

  assign cap_edge  = capture_edge_select ? (cap_sync & ~cap_prev)
                                         : (~cap_sync & cap_prev);
  // Input is cut off while the register defines the period
  assign cap_event = cap_edge & ~cap_is_top;

  // ----------------------------------------------------------------
  // Capture register and shared high-byte latch
  // ----------------------------------------------------------------

  // A capture in the same cycle as a software low-byte write wins,
  // since the snapshot of the counter is the more perishable value
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      capture_value <= `T16C_RESET_CAPTURE;
      temp_high     <= 8'h00;
    end else begin
      if (cap_event) begin
        capture_value <= counter_value;
      end else if (wr_cap_lo) begin
        capture_value <= {temp_high, reg_wdata};
      end
      // A low-byte read parks the high byte so a later high read
      // returns the same snapshot
      if (wr_cap_hi) begin
        temp_high <= reg_wdata;
      end else if (rd_cap_lo) begin
        temp_high <= capture_value[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags and mask
  // ----------------------------------------------------------------

  // Forced compare strobes are not inputs here, so only a real
  // equality on a timer tick can set a match flag
  always @* begin
    flag_set = irq_pack({
      cap_event | (cap_is_top & count_tick &
                   (counter_value == capture_value)),
      count_tick & (counter_value == compare_b_value),
      count_tick & (counter_value == compare_a_value),
      counter_wrap});
    flag_clear = irq_pack(irq_ack);
    if (wr_flags) begin
      flag_clear = flag_clear | (reg_wdata & `T16C_IRQ_BITS);
    end
    next_flags = ((irq_flags & ~flag_clear) | flag_set) & `T16C_IRQ_BITS;
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_flags <= `T16C_RESET_FLAGS;
      irq_mask  <= `T16C_RESET_MASK;
    end else begin
      irq_flags <= next_flags;
      // Reserved positions never store, so they read back zero
      if (wr_mask) begin
        irq_mask <= reg_wdata & `T16C_IRQ_BITS;
      end
    end
  end

  // Requests are combinational so the vector logic sees a flag in the
  // cycle it is set; the global enable gates all four together
  assign irq_req = {irq_flags[`T16C_BIT_CAPTURE] & irq_mask[`T16C_BIT_CAPTURE],
                    irq_flags[`T16C_BIT_MATCH_B] & irq_mask[`T16C_BIT_MATCH_B],
                    irq_flags[`T16C_BIT_MATCH_A] & irq_mask[`T16C_BIT_MATCH_A],
                    irq_flags[`T16C_BIT_WRAP]    & irq_mask[`T16C_BIT_WRAP]}
                   & {4{global_irq_en}};

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------

  // High byte reads return the latch, so a low-then-high pair is atomic
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `T16C_ADDR_FLAGS:  reg_rdata <= irq_flags;
        `T16C_ADDR_MASK:   reg_rdata <= irq_mask;
        `T16C_ADDR_CAP_LO: reg_rdata <= capture_value[7:0];
        `T16C_ADDR_CAP_HI: reg_rdata <= temp_high;
        default:           reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

/* File: verification/t16c_chk.sv */
`timescale 1ns/1ns
`include "t16c_defines.vh"
module t16c_chk (
  input wire        clock,
  input wire        rst_b,
  input wire [7:0]  reg_addr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire [2:0]  clock_select_bits,
  input wire [2:0]  clock_select_t0_bits,
  input wire        prescaler_reset,
  input wire        ext_count_pin,
  input wire        global_irq_en,
  input wire [3:0]  irq_req,
  input wire        count_tick,
  input wire        count_tick_t0,
  input wire [7:0]  temp_byte
);
  // ----
  // Free-running prescaler mirror
  // ----
  reg  [9:0] presc;
  wire [2:0] cs = clock_select_bits;
  always @(posedge clock or negedge rst_b)
    if (!rst_b)
      presc <= 10'h000;
    else if (prescaler_reset)
      presc <= 10'h000;
    else
      presc <= presc + 10'h001;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  property p_gate; irq_req != 4'h0 |-> global_irq_en; endproperty
  a_gate: assert property (p_gate) else $error("request without global enable");
  property p_resv; $past(reg_rd) && ($past(reg_addr) == `T16C_ADDR_FLAGS
    || $past(reg_addr) == `T16C_ADDR_MASK) |-> (reg_rdata & 8'hD8) == 8'h00; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_direct; cs == `T16C_CS_DIRECT |-> count_tick; endproperty
  a_direct: assert property (p_direct) else $error("direct tick missing");
  property p_div8; cs == `T16C_CS_DIV8 |-> count_tick == (presc[2:0] == 3'h7); endproperty
  a_div8: assert property (p_div8) else $error("div8 tick wrong");
  property p_shared; clock_select_t0_bits == `T16C_CS_DIV64
    |-> count_tick_t0 == (presc[5:0] == 6'h3F); endproperty
  a_shared: assert property (p_shared) else $error("shared tap wrong");
  property p_rise; cs == `T16C_CS_PIN_RISE && count_tick
    |-> $past(ext_count_pin, 2) && !$past(ext_count_pin, 3); endproperty
  a_rise: assert property (p_rise) else $error("rise tick wrong");
  property p_fall; cs == `T16C_CS_PIN_FALL && count_tick
    |-> !$past(ext_count_pin, 2) && $past(ext_count_pin, 3); endproperty
  a_fall: assert property (p_fall) else $error("fall tick wrong");
  property p_hiread; $past(reg_rd) && $past(reg_addr) == `T16C_ADDR_CAP_HI
    |-> reg_rdata == $past(temp_byte); endproperty
  a_hiread: assert property (p_hiread) else $error("high byte not from latch");
endmodule
bind t16c_top t16c_chk u_chk (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clock_select_bits(clock_select_bits),
  .clock_select_t0_bits(clock_select_t0_bits), .prescaler_reset(prescaler_reset),
  .ext_count_pin(ext_count_pin), .global_irq_en(global_irq_en), .irq_req(irq_req),
  .count_tick(count_tick), .count_tick_t0(count_tick_t0), .temp_byte(temp_byte));

/* File: verification/t16c_pin_model.sv */
`timescale 1ns/1ns
// ----
// Far-side pins
// ----
module t16c_pin_model (
  input  wire       clock,
  input  wire       rst_b,
  input  wire       cap_level,
  input  wire       ext_run,
  input  wire [3:0] ext_half,
  output reg        capture_pin,
  output reg        ext_count_pin
);
  reg [3:0] hcnt;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      capture_pin <= 1'b0;
      ext_count_pin <= 1'b0;
      hcnt <= 4'h0;
    end else begin
      capture_pin <= cap_level;
      hcnt <= hcnt + 4'h1;
      // Stops only when low, so select changes always see a quiet pin
      if ((ext_run || ext_count_pin) && hcnt + 4'h1 >= ext_half && hcnt != 4'h0) begin
        ext_count_pin <= ~ext_count_pin;
        hcnt <= 4'h0;
      end
    end
  end
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
`include "t16c_defines.vh"
module tb_top;
  reg         clock, rst_b, reg_wr, reg_rd, counter_wrap, psr, cap_level;
  reg         cmp_out, cmp_sel, ces, ext_run, gie;
  reg  [7:0]  reg_addr, reg_wdata, v;
  reg  [15:0] counter_value, cmp_a, cmp_b;
  reg  [3:0]  wgm, ext_half, irq_ack;
  reg  [2:0]  sel, sel0;
  wire [7:0]  reg_rdata, temp_byte;
  wire [3:0]  irq_req;
  wire [15:0] capture_top;
  wire        count_tick, capture_pin, ext_count_pin;
  integer     fail_count, check_count, ticks, rises, i;
  t16c_top dut (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .counter_value, .compare_a_value(cmp_a), .compare_b_value(cmp_b), .counter_wrap,
    .waveform_mode_bits(wgm), .clock_select_bits(sel), .clock_select_t0_bits(sel0),
    .prescaler_reset(psr), .capture_pin, .comparator_out(cmp_out),
    .comparator_capture_sel(cmp_sel), .capture_edge_select(ces), .ext_count_pin,
    .ext_count_pin_t0(1'b0), .global_irq_en(gie), .irq_ack, .irq_req, .count_tick,
    .count_tick_t0(), .capture_top, .temp_byte);
  t16c_pin_model pm (.clock, .rst_b, .cap_level, .ext_run, .ext_half, .capture_pin,
    .ext_count_pin);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Ticks are combinational, so count them away from the launching edge
  always @(negedge clock)
    if (count_tick === 1'b1)
      ticks = ticks + 1;
  always @(posedge ext_count_pin)
    rises = rises + 1;
  // ----
  // Checks and bus cycles
  // ----
  task chk(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] x);
    begin
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= x;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      #1;
    end
  endtask
  task rchk(input [7:0] a, input [7:0] exp);
    begin
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk({8'h00, reg_rdata}, {8'h00, exp});
    end
  endtask
  function [15:0] f_ticks(input [2:0] c);
    case (c)
      `T16C_CS_DIRECT: f_ticks = 16'h0800;
      `T16C_CS_DIV8: f_ticks = 16'h0100;
      `T16C_CS_DIV64: f_ticks = 16'h0020;
      `T16C_CS_DIV256: f_ticks = 16'h0008;
      `T16C_CS_DIV1024: f_ticks = 16'h0002;
      default: f_ticks = 16'h0000;
    endcase
  endfunction
  task complete_run;
    begin
      if (fail_count == 0 && check_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    #200000;
    fail_count = fail_count + 1;
    complete_run;
  end
  // ----
  // Main sequence
  // ----
  initial begin
    {rst_b, reg_addr, reg_wdata, reg_wr, reg_rd, counter_value, counter_wrap} = '0;
    {wgm, sel, sel0, psr, cap_level, cmp_out, cmp_sel, ces, ext_run, gie, irq_ack} = '0;
    {cmp_a, cmp_b, ext_half} = {16'hFFFF, 16'hFFFE, 4'h2};
    {fail_count, check_count, ticks, rises} = '0;
    i = $urandom(90959);
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    rchk(`T16C_ADDR_FLAGS, `T16C_RESET_FLAGS);
    rchk(`T16C_ADDR_MASK, `T16C_RESET_MASK);
    rchk(`T16C_ADDR_CAP_LO, 8'h00);
    rchk(`T16C_ADDR_CAP_HI, 8'h00);
    rchk(8'h00, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      v = 8'($urandom);
      wr(`T16C_ADDR_MASK, v);
      rchk(`T16C_ADDR_MASK, v & `T16C_IRQ_BITS);
    end
    wr(`T16C_ADDR_MASK, 8'hFF);
    gie <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      counter_value <= 16'($urandom) & 16'h7FFF;
      {cmp_sel, ces} <= 2'(i);
      repeat (8) @(posedge clock);
      wr(`T16C_ADDR_FLAGS, 8'hFF);
      if (cmp_sel) cmp_out <= !ces; else cap_level <= !ces;
      repeat (8) @(posedge clock);
      rchk(`T16C_ADDR_FLAGS, 8'h00);
      if (cmp_sel) cmp_out <= ces; else cap_level <= ces;
      repeat (8) @(posedge clock);
      rchk(`T16C_ADDR_FLAGS, 8'h20);
      chk({12'h000, irq_req}, 16'h0008);
      rchk(`T16C_ADDR_CAP_LO, counter_value[7:0]);
      rchk(`T16C_ADDR_CAP_HI, counter_value[15:8]);
      wr(`T16C_ADDR_FLAGS, 8'hDF);
      rchk(`T16C_ADDR_FLAGS, 8'h20);
      if (ces) irq_ack <= 4'h8; else wr(`T16C_ADDR_FLAGS, 8'h20);
      @(posedge clock);
      irq_ack <= 4'h0;
      rchk(`T16C_ADDR_FLAGS, 8'h00);
    end
    sel <= `T16C_CS_DIRECT;
    {cmp_a, cmp_b} <= {counter_value, counter_value};
    repeat (2) @(posedge clock);
    {cmp_a, cmp_b, counter_wrap} <= {16'hFFFF, 16'hFFFE, 1'b1};
    @(posedge clock);
    counter_wrap <= 1'b0;
    rchk(`T16C_ADDR_FLAGS, 8'h07);
    chk({12'h000, irq_req}, 16'h0007);
    gie <= 1'b0;
    #1 chk({12'h000, irq_req}, 16'h0000);
    gie <= 1'b1;
    {reg_addr, reg_wdata, reg_wr, counter_wrap} <= {`T16C_ADDR_FLAGS, 8'h01, 2'b11};
    @(posedge clock);
    {reg_wr, counter_wrap} <= 2'b00;
    rchk(`T16C_ADDR_FLAGS, 8'h07);
    wr(`T16C_ADDR_MASK, 8'h20);
    chk({12'h000, irq_req}, 16'h0000);
    wr(`T16C_ADDR_FLAGS, 8'h07);
    rchk(`T16C_ADDR_FLAGS, 8'h00);
    {wgm, counter_value} <= {`T16C_WGM_CTC_CAP, 16'h1200};
    wr(`T16C_ADDR_CAP_HI, 8'h12);
    chk({8'h00, temp_byte}, 16'h0012);
    wr(`T16C_ADDR_CAP_LO, 8'h34);
    chk(capture_top, 16'h1234);
    cmp_out <= 1'b0;
    repeat (4) @(posedge clock);
    cmp_out <= 1'b1;
    repeat (8) @(posedge clock);
    rchk(`T16C_ADDR_FLAGS, 8'h00);
    rchk(`T16C_ADDR_CAP_LO, 8'h34);
    counter_value <= 16'h1234;
    repeat (2) @(posedge clock);
    counter_value <= 16'h0000;
    rchk(`T16C_ADDR_FLAGS, 8'h20);
    wgm <= 4'h0;
    for (i = 0; i < 6; i = i + 1) begin
      {sel, sel0} <= {3'(i), 3'($urandom % 6)};
      @(posedge clock);
      #1 ticks = 0;
      repeat (2048) @(posedge clock);
      chk(ticks[15:0], f_ticks(sel));
      psr <= 1'b1;
      repeat (3) @(posedge clock);
      psr <= 1'b0;
    end
    for (i = 6; i < 8; i = i + 1) begin
      sel <= 3'(i);
      repeat (4) @(posedge clock);
      {ticks, rises} = {32'd0, 32'd0};
      {ext_run, ext_half} <= {1'b1, 4'($urandom % 3) + 4'h2};
      repeat (60) @(posedge clock);
      ext_run <= 1'b0;
      repeat (20) @(posedge clock);
      chk(ticks[15:0], rises[15:0]);
    end
    complete_run;
  end
endmodule
